/* verilog/tsc_sensor_regs.sv */
// Behaviour
// - config bits 15:11 ignore writes and read as zero
// - hysteresis field selects none, 1.5, 3 or 6 degrees
// - power-down zero updates reading per sample; one stops converter, holds reading
// - power-down cannot be set while a lock is set; clearing always allowed
// - critical lock blocks critical limit writes; only reset clears it
// - alarm lock blocks high and low limit writes; only reset clears it
// - either lock freezes hysteresis, output enable, polarity and mode bits
// - clear request clears recorded event in interrupt mode only; reads zero
// - above critical limit, clear request does not de-assert the alert
// - alert status is read-only, polarity independent, gated by output enable
// - output disabled: released for polarity zero, grounded for polarity one
// - critical-only zero: alarm or critical crossing; one: critical only
// - critical-only cannot be set while alarm lock is set
// - polarity zero active low, one active high
// - mode zero comparator, one interrupt
// - limits signed, sign bit 12, lsb 0.25 at bit 2, others zero
// - temperature signed in bits 12:0, lsb 0.0625, unsupported bits zero
// - critical status set when temperature at or above critical limit
// - high status set only when temperature strictly above high limit
// - low status set only when temperature strictly below low limit
// - reset clears power-down so conversion starts active
// - interrupt mode asserts on each window crossing, holds until cleared
// - comparator asserts outside window; critical-only asserts above critical, ignores clears
// - clear above critical limit is held and acts once temperature drops below it and to limit minus hysteresis
// - limits and temperature use two's complement encoding
`timescale 1ns/100ps
`default_nettype none
module tsc_sensor_regs
  import tsc_pkg::*;
(
  input  wire logic                  I_CLK,
  input  wire logic                  I_NRST,
  input  wire logic [7:0]            I_REG_INDEX,
  input  wire logic                  I_REG_WR,
  input  wire logic [15:0]           I_REG_WDATA,
  output logic      [15:0]           O_REG_RDATA,
  input  wire logic                  I_SAMPLE_VALID,
  input  wire logic [TSC_TEMP_W-1:0] I_SAMPLE_TEMP,
  output logic                       O_CONV_ENABLE,
  output logic                       O_EVENT_OUT,
  output logic                       O_EVENT_OE
);
  logic [1:0]            hysteresis_select_q;
  logic                  power_down_q;
  logic                  crit_lock_q;
  logic                  alarm_lock_q;
  logic                  out_en_q;
  logic                  crit_only_q;
  logic                  polarity_q;
  logic                  mode_q;
  logic [TSC_TEMP_W-1:0] high_limit_q;
  logic [TSC_TEMP_W-1:0] low_limit_q;
  logic [TSC_TEMP_W-1:0] crit_limit_q;
  logic [TSC_TEMP_W-1:0] temp_q;
  logic                  event_q;
  logic                  clear_pend_q;
  logic                  window_prev_q;
  logic                  asserted_q;
  logic [15:0]           rdata_q;

  logic                  lock_any;
  logic                  cfg_wr;
  logic                  clear_req;
  logic [13:0]           hysteresis_select_amount;
  logic                  crit_status;
  logic                  high_status;
  logic                  low_status;
  logic                  crit_trip;
  logic                  high_trip;
  logic                  low_trip;
  logic                  window_cond;
  logic                  clear_fire;
  logic                  event_set;
  logic                  asserted_d;
  logic                  alert_status;
  logic [15:0]           cfg_read;
  logic [15:0]           temp_read;
  logic                  high_wr;
  logic                  low_wr;
  logic                  crit_wr;
  logic [15:0]           rdata_d;

  assign lock_any  = crit_lock_q | alarm_lock_q;
  assign cfg_wr    = I_REG_WR && (I_REG_INDEX == TSC_IDX_CONFIG);
  assign clear_req = cfg_wr && I_REG_WDATA[TSC_CFG_CLEAR];
  // one decode per limit keeps the lock gating next to each register
  assign high_wr   = I_REG_WR && (I_REG_INDEX == TSC_IDX_HIGH_LIMIT);
  assign low_wr    = I_REG_WR && (I_REG_INDEX == TSC_IDX_LOW_LIMIT);
  assign crit_wr   = I_REG_WR && (I_REG_INDEX == TSC_IDX_CRIT_LIMIT);

  // configuration: frozen fields only move while no lock is set
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      hysteresis_select_q <= TSC_REG_RESET[TSC_CFG_HYSTERESIS_SELECT_HI:TSC_CFG_HYSTERESIS_SELECT_LO];
    end else if (cfg_wr && !lock_any) begin
      hysteresis_select_q <= I_REG_WDATA[TSC_CFG_HYSTERESIS_SELECT_HI:TSC_CFG_HYSTERESIS_SELECT_LO];
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      out_en_q   <= TSC_REG_RESET[TSC_CFG_OUT_EN];
      polarity_q <= TSC_REG_RESET[TSC_CFG_POLARITY];
      mode_q     <= TSC_REG_RESET[TSC_CFG_MODE];
    end else if (cfg_wr && !lock_any) begin
      out_en_q   <= I_REG_WDATA[TSC_CFG_OUT_EN];
      polarity_q <= I_REG_WDATA[TSC_CFG_POLARITY];
      mode_q     <= I_REG_WDATA[TSC_CFG_MODE];
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      power_down_q <= TSC_REG_RESET[TSC_CFG_PDOWN];
    end else if (cfg_wr) begin
      if (!I_REG_WDATA[TSC_CFG_PDOWN]) begin
        power_down_q <= 1'b0;
      end else if (!lock_any) begin
        power_down_q <= 1'b1;
      end
    end
  end

  // locks are sticky; a written zero is simply ignored
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      crit_lock_q <= TSC_REG_RESET[TSC_CFG_CRIT_LOCK];
    end else if (cfg_wr) begin
      crit_lock_q <= crit_lock_q | I_REG_WDATA[TSC_CFG_CRIT_LOCK];
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      alarm_lock_q <= TSC_REG_RESET[TSC_CFG_ALARM_LOCK];
    end else if (cfg_wr) begin
      alarm_lock_q <= alarm_lock_q | I_REG_WDATA[TSC_CFG_ALARM_LOCK];
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      crit_only_q <= TSC_REG_RESET[TSC_CFG_CRIT_ONLY];
    end else if (cfg_wr) begin
      if (!I_REG_WDATA[TSC_CFG_CRIT_ONLY]) begin
        crit_only_q <= 1'b0;
      end else if (!alarm_lock_q) begin
        crit_only_q <= 1'b1;
      end
    end
  end

  // limit registers, low two bits and bits above the sign dropped
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      high_limit_q <= TSC_REG_RESET[TSC_TEMP_W-1:0];
    end else if (high_wr && !alarm_lock_q) begin
      high_limit_q <= I_REG_WDATA[TSC_TEMP_W-1:0] & TSC_LIMIT_MASK;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      low_limit_q <= TSC_REG_RESET[TSC_TEMP_W-1:0];
    end else if (low_wr && !alarm_lock_q) begin
      low_limit_q <= I_REG_WDATA[TSC_TEMP_W-1:0] & TSC_LIMIT_MASK;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      crit_limit_q <= TSC_REG_RESET[TSC_TEMP_W-1:0];
    end else if (crit_wr && !crit_lock_q) begin
      crit_limit_q <= I_REG_WDATA[TSC_TEMP_W-1:0] & TSC_LIMIT_MASK;
    end
  end

  // reading held while powered down; converter told to stop
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      temp_q <= TSC_TEMP_RESET;
    end else if (I_SAMPLE_VALID && !power_down_q) begin
      temp_q <= I_SAMPLE_TEMP & TSC_TEMP_RES_MASK;
    end
  end

  assign O_CONV_ENABLE = !power_down_q;

  always_comb begin
    case (tsc_hysteresis_select_type'(hysteresis_select_q))
      TSC_HYSTERESIS_SELECT_NONE_SEL: hysteresis_select_amount = TSC_HYSTERESIS_SELECT_OFF;
      TSC_HYSTERESIS_SELECT_1P5_SEL:  hysteresis_select_amount = TSC_HYSTERESIS_SELECT_1P5;
      TSC_HYSTERESIS_SELECT_3P0_SEL:  hysteresis_select_amount = TSC_HYSTERESIS_SELECT_3P0;
      TSC_HYSTERESIS_SELECT_6P0_SEL:  hysteresis_select_amount = TSC_HYSTERESIS_SELECT_6P0;
      default:           hysteresis_select_amount = TSC_HYSTERESIS_SELECT_OFF;
    endcase
  end

  // comparisons read live register values, so a limit write acts at once
  tsc_limit_cmp #(.UPPER(1'b1), .INCL(1'b1)) u_crit_cmp (
    .i_clk    (I_CLK),
    .i_nrst   (I_NRST),
    .i_temp   (temp_q),
    .i_limit  (crit_limit_q),
    .i_hysteresis_select   (hysteresis_select_amount),
    .o_status (crit_status),
    .o_trip   (crit_trip)
  );

  tsc_limit_cmp #(.UPPER(1'b1), .INCL(1'b0)) u_high_cmp (
    .i_clk    (I_CLK),
    .i_nrst   (I_NRST),
    .i_temp   (temp_q),
    .i_limit  (high_limit_q),
    .i_hysteresis_select   (hysteresis_select_amount),
    .o_status (high_status),
    .o_trip   (high_trip)
  );

  tsc_limit_cmp #(.UPPER(1'b0), .INCL(1'b0)) u_low_cmp (
    .i_clk    (I_CLK),
    .i_nrst   (I_NRST),
    .i_temp   (temp_q),
    .i_limit  (low_limit_q),
    .i_hysteresis_select   (hysteresis_select_amount),
    .o_status (low_status),
    .o_trip   (low_trip)
  );

  assign window_cond = high_trip | low_trip;
  // a clear is only carried out once the critical condition has gone
  assign clear_fire  = (clear_req | clear_pend_q) && !crit_trip;
  assign event_set   = window_cond != window_prev_q;

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      window_prev_q <= 1'b0;
    end else begin
      window_prev_q <= window_cond;
    end
  end

  // pending clear only matters in interrupt mode without critical-only
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      clear_pend_q <= 1'b0;
    end else if (!mode_q || crit_only_q || clear_fire) begin
      clear_pend_q <= 1'b0;
    end else if (clear_req && crit_trip) begin
      clear_pend_q <= 1'b1;
    end
  end

  // recorded event: a new crossing beats a clear in the same cycle
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      event_q <= 1'b0;
    end else if (!mode_q || crit_only_q) begin
      event_q <= 1'b0;
    end else if (event_set) begin
      event_q <= 1'b1;
    end else if (clear_fire) begin
      event_q <= 1'b0;
    end
  end

  always_comb begin
    if (crit_only_q) begin
      asserted_d = crit_trip;
    end else if (!mode_q) begin
      asserted_d = window_cond | crit_trip;
    end else begin
      asserted_d = event_q | event_set | crit_trip;
    end
  end

  // shutdown freezes the alert state, a clear request may still drop it
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      asserted_q <= 1'b0;
    end else if (!power_down_q) begin
      asserted_q <= asserted_d;
    end else if (clear_fire && mode_q && !crit_only_q) begin
      asserted_q <= 1'b0;
    end
  end

  tsc_event_pin u_event_pin (
    .i_clk      (I_CLK),
    .i_nrst     (I_NRST),
    .i_asserted (asserted_q),
    .i_enable   (out_en_q),
    .i_polarity (polarity_q),
    .o_pin_out  (O_EVENT_OUT),
    .o_pin_oe   (O_EVENT_OE),
    .o_status   (alert_status)
  );

  always_comb begin
    cfg_read                                    = TSC_REG_RESET;
    cfg_read[TSC_CFG_HYSTERESIS_SELECT_HI:TSC_CFG_HYSTERESIS_SELECT_LO]   = hysteresis_select_q;
    cfg_read[TSC_CFG_PDOWN]                     = power_down_q;
    cfg_read[TSC_CFG_CRIT_LOCK]                 = crit_lock_q;
    cfg_read[TSC_CFG_ALARM_LOCK]                = alarm_lock_q;
    cfg_read[TSC_CFG_STATUS]                    = alert_status;
    cfg_read[TSC_CFG_OUT_EN]                    = out_en_q;
    cfg_read[TSC_CFG_CRIT_ONLY]                 = crit_only_q;
    cfg_read[TSC_CFG_POLARITY]                  = polarity_q;
    cfg_read[TSC_CFG_MODE]                      = mode_q;
  end

  always_comb begin
    temp_read                   = TSC_REG_RESET;
    temp_read[TSC_TEMP_W-1:0]   = temp_q;
    temp_read[TSC_TDR_CRIT]     = crit_status;
    temp_read[TSC_TDR_HIGH]     = high_status;
    temp_read[TSC_TDR_LOW]      = low_status;
  end

  // read mux; unmapped indices read zero
  always_comb begin
    case (I_REG_INDEX)
      TSC_IDX_CONFIG:     rdata_d = cfg_read;
      TSC_IDX_HIGH_LIMIT: rdata_d = {3'h0, high_limit_q};
      TSC_IDX_LOW_LIMIT:  rdata_d = {3'h0, low_limit_q};
      TSC_IDX_CRIT_LIMIT: rdata_d = {3'h0, crit_limit_q};
      TSC_IDX_TEMP:       rdata_d = temp_read;
      default:            rdata_d = TSC_REG_RESET;
    endcase
  end

  // one cycle of read latency gives the serial engine a settled word
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rdata_q <= TSC_REG_RESET;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign O_REG_RDATA = rdata_q;
endmodule : tsc_sensor_regs
`default_nettype wire

/* verilog/tsc_pkg.sv */
package tsc_pkg;
  // register pointer indices
  localparam logic [7:0]  TSC_IDX_CONFIG     = 8'h01;
  localparam logic [7:0]  TSC_IDX_HIGH_LIMIT = 8'h02;
  localparam logic [7:0]  TSC_IDX_LOW_LIMIT  = 8'h03;
  localparam logic [7:0]  TSC_IDX_CRIT_LIMIT = 8'h04;
  localparam logic [7:0]  TSC_IDX_TEMP       = 8'h05;
  // configuration field positions
  localparam int          TSC_CFG_HYSTERESIS_SELECT_HI    = 10;
  localparam int          TSC_CFG_HYSTERESIS_SELECT_LO    = 9;
  localparam int          TSC_CFG_PDOWN      = 8;
  localparam int          TSC_CFG_CRIT_LOCK  = 7;
  localparam int          TSC_CFG_ALARM_LOCK = 6;
  localparam int          TSC_CFG_CLEAR      = 5;
  localparam int          TSC_CFG_STATUS     = 4;
  localparam int          TSC_CFG_OUT_EN     = 3;
  localparam int          TSC_CFG_CRIT_ONLY  = 2;
  localparam int          TSC_CFG_POLARITY   = 1;
  localparam int          TSC_CFG_MODE       = 0;
  // temperature register status positions
  localparam int          TSC_TDR_CRIT       = 15;
  localparam int          TSC_TDR_HIGH       = 14;
  localparam int          TSC_TDR_LOW        = 13;
  localparam int          TSC_TEMP_W         = 13;
  // limits keep bits 12:2, temperature keeps bits 12:0 at full resolution
  localparam logic [12:0] TSC_LIMIT_MASK     = 13'h1FFC;
  localparam logic [12:0] TSC_TEMP_RES_MASK  = 13'h1FFF;
  localparam logic [15:0] TSC_REG_RESET      = 16'h0000;
  localparam logic [12:0] TSC_TEMP_RESET     = 13'h0000;
  // hysteresis in 0.0625 degree steps: 0, 1.5, 3, 6 degrees
  localparam logic [13:0] TSC_HYSTERESIS_SELECT_OFF       = 14'h0000;
  localparam logic [13:0] TSC_HYSTERESIS_SELECT_1P5       = 14'h0018;
  localparam logic [13:0] TSC_HYSTERESIS_SELECT_3P0       = 14'h0030;
  localparam logic [13:0] TSC_HYSTERESIS_SELECT_6P0       = 14'h0060;

  typedef enum logic [1:0] {
    TSC_HYSTERESIS_SELECT_NONE_SEL = 2'b00,
    TSC_HYSTERESIS_SELECT_1P5_SEL  = 2'b01,
    TSC_HYSTERESIS_SELECT_3P0_SEL  = 2'b10,
    TSC_HYSTERESIS_SELECT_6P0_SEL  = 2'b11
  } tsc_hysteresis_select_type;
endpackage : tsc_pkg

/* verilog/tsc_limit_cmp.sv */
`timescale 1ns/100ps
`default_nettype none
module tsc_limit_cmp
  import tsc_pkg::*;
#(
  parameter bit UPPER = 1'b1,
  parameter bit INCL  = 1'b0
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_nrst,
  input  wire logic [TSC_TEMP_W-1:0] i_temp,
  input  wire logic [TSC_TEMP_W-1:0] i_limit,
  input  wire logic [13:0]           i_hysteresis_select,
  output logic                       o_status,
  output logic                       o_trip
);
  logic signed [13:0] temp_s;
  logic signed [13:0] limit_s;
  logic signed [13:0] release_s;
  logic               trip_q;
  logic               trip_d;

  // sign-extend both to 14 bits so the hysteresis offset cannot wrap
  assign temp_s    = signed'({i_temp[TSC_TEMP_W-1], i_temp});
  assign limit_s   = signed'({i_limit[TSC_TEMP_W-1], i_limit});
  assign release_s = limit_s - signed'(i_hysteresis_select);

  // raw relation, unaffected by hysteresis or event settings
  always_comb begin
    if (UPPER) begin
      o_status = INCL ? (temp_s >= limit_s) : (temp_s > limit_s);
    end else begin
      o_status = temp_s < limit_s;
    end
  end

  // hysteresis only widens the release side of an upper limit
  always_comb begin
    if (!UPPER) begin
      trip_d = o_status;
    end else if (o_status) begin
      trip_d = 1'b1;
    end else if (temp_s <= release_s) begin
      trip_d = 1'b0;
    end else begin
      trip_d = trip_q;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      trip_q <= 1'b0;
    end else begin
      trip_q <= trip_d;
    end
  end

  assign o_trip = trip_d;
endmodule : tsc_limit_cmp
`default_nettype wire

/* verilog/tsc_event_pin.sv */
`timescale 1ns/100ps
`default_nettype none
module tsc_event_pin
  import tsc_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_asserted,
  input  wire logic i_enable,
  input  wire logic i_polarity,
  output logic      o_pin_out,
  output logic      o_pin_oe,
  output logic      o_status
);
  logic level_high;
  logic oe_q;

  // enabled: active low or high per polarity; disabled: released or grounded
  always_comb begin
    if (i_enable) begin
      level_high = i_polarity ? i_asserted : !i_asserted;
    end else begin
      level_high = !i_polarity;
    end
  end

  // open drain: only ever pulls low, the pull-up makes the high level
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= !level_high;
    end
  end

  assign o_pin_out = 1'b0;
  assign o_pin_oe  = oe_q;
  assign o_status  = i_enable & i_asserted;
endmodule : tsc_event_pin
`default_nettype wire

/* verification/tsc_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module tsc_host_model (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_rdata,
  output logic      [7:0]  o_index,
  output logic             o_wr,
  output logic      [15:0] o_wdata
);
  initial begin
    o_index = 8'h00;
    o_wr    = 1'b0;
    o_wdata = 16'h0000;
  end

  // data is scrambled after the strobe so a late sample cannot pass
  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    @(negedge i_clk);
    o_wr    = 1'b1;
    o_index = idx;
    o_wdata = d;
    @(negedge i_clk);
    o_wr    = 1'b0;
    o_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] idx, output logic [15:0] d);
    @(negedge i_clk);
    o_index = idx;
    @(negedge i_clk);
    d = i_rdata;
  endtask : rd
endmodule : tsc_host_model
`default_nettype wire

/* verification/tsc_sensor_regs_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module tsc_sensor_regs_sva
  import tsc_pkg::*;
(
  input wire logic        I_CLK,
  input wire logic        I_NRST,
  input wire logic [7:0]  I_REG_INDEX,
  input wire logic        I_REG_WR,
  input wire logic [15:0] I_REG_WDATA,
  input wire logic [15:0] O_REG_RDATA,
  input wire logic        I_SAMPLE_VALID,
  input wire logic [12:0] I_SAMPLE_TEMP,
  input wire logic        O_CONV_ENABLE,
  input wire logic        O_EVENT_OUT,
  input wire logic        O_EVENT_OE
);
  logic [7:0] idx_q;
  logic [2:0] quiet_q;
  logic [1:0] lock_q;
  wire        rd_cfg = idx_q == TSC_IDX_CONFIG;

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_NRST);

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) idx_q <= 8'h00;
    else idx_q <= I_REG_INDEX;
  end
  // pin and read data only agree once the pipeline has settled
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) quiet_q <= 3'h0;
    else if (I_REG_WR || I_SAMPLE_VALID) quiet_q <= 3'h0;
    else if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
  end
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) lock_q <= 2'h0;
    else if (rd_cfg) lock_q <= lock_q | O_REG_RDATA[7:6];
  end

  sequence s_cfg_quiet;
    rd_cfg && quiet_q >= 3'h4;
  endsequence
  sequence s_pd_req;
    I_REG_WR && I_REG_INDEX == TSC_IDX_CONFIG && I_REG_WDATA[TSC_CFG_PDOWN];
  endsequence

  a_rsvd_zero:
    assert property (rd_cfg |-> O_REG_RDATA[15:11] == 5'h00 && !O_REG_RDATA[5])
    else $error("config reserved bits nonzero");
  a_limit_fmt:
    assert property (idx_q inside {8'h02, 8'h03, 8'h04} |->
      O_REG_RDATA[15:13] == 3'h0 && O_REG_RDATA[1:0] == 2'h0)
    else $error("limit unused bits nonzero");
  a_status_gate:
    assert property (rd_cfg && !O_REG_RDATA[3] |-> !O_REG_RDATA[4])
    else $error("status set while output disabled");
  a_pin_level:
    assert property (s_cfg_quiet |-> O_EVENT_OE == (O_REG_RDATA[4] ^ O_REG_RDATA[1]))
    else $error("pin level disagrees with status and polarity");
  a_pd_conv:
    assert property (s_cfg_quiet |-> O_CONV_ENABLE == !O_REG_RDATA[8])
    else $error("converter enable disagrees with power-down");
  a_lock_sticky:
    assert property (rd_cfg |-> (O_REG_RDATA[7:6] & lock_q) == lock_q)
    else $error("lock bit cleared without reset");
  a_pd_refused:
    assert property (s_pd_req ##0 (|lock_q && O_CONV_ENABLE) |=> O_CONV_ENABLE [*2])
    else $error("power-down accepted while locked");
  a_pd_clear:
    assert property (I_REG_WR && I_REG_INDEX == TSC_IDX_CONFIG && !I_REG_WDATA[8]
      |=> O_CONV_ENABLE)
    else $error("power-down clear refused");
  a_temp_hold:
    assert property (idx_q == TSC_IDX_TEMP && $past(idx_q) == TSC_IDX_TEMP &&
      !O_CONV_ENABLE && !$past(O_CONV_ENABLE) && !$past(O_CONV_ENABLE, 2)
      |-> $stable(O_REG_RDATA[12:0]))
    else $error("reading changed during power-down");
  a_event_od:
    assert property (O_EVENT_OUT == 1'b0)
    else $error("event data not low");
  a_reset_rel:
    assert property ($rose(I_NRST) |->
      O_CONV_ENABLE && !O_EVENT_OE && O_REG_RDATA == 16'h0000)
    else $error("wrong state after reset");
endmodule : tsc_sensor_regs_sva
`default_nettype wire

/* verification/tsc_sensor_regs_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin n_fail++; \
  $display("Error %s exp %h got %h", n, e, a); end end
module tsc_sensor_regs_tb_top
  import tsc_pkg::*;
;
  logic        clk, nrst, wr, sv, conv, ev_out, ev_oe, ea;
  logic [7:0]  idx;
  logic [15:0] wdata, rdata, cfg, rv;
  logic [15:0] lim [2:4];
  logic [12:0] st, tmp;
  int          n_fail, checks, seed;

  tsc_sensor_regs dut_u (
    .I_CLK(clk), .I_NRST(nrst), .I_REG_INDEX(idx), .I_REG_WR(wr),
    .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .I_SAMPLE_VALID(sv),
    .I_SAMPLE_TEMP(st), .O_CONV_ENABLE(conv), .O_EVENT_OUT(ev_out),
    .O_EVENT_OE(ev_oe));
  tsc_host_model host_u (
    .i_clk(clk), .i_rdata(rdata), .o_index(idx), .o_wr(wr), .o_wdata(wdata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic int sx(input logic [12:0] v);
    return v[12] ? int'(v) - 8192 : int'(v);
  endfunction : sx

  function automatic logic [15:0] xr(input int i);
    case (i)
      1: return {cfg[15:5], ea & cfg[3], cfg[3:0]};
      5: return {sx(tmp) >= sx(lim[4][12:0]), sx(tmp) > sx(lim[2][12:0]),
                 sx(tmp) < sx(lim[3][12:0]), tmp};
      default: return lim[i];
    endcase
  endfunction : xr

  task automatic rst_mdl;
    cfg = 16'h0000;
    lim = '{default: 16'h0000};
    tmp = 13'h0000;
    ea  = 1'b0;
  endtask : rst_mdl

  task automatic c(input int i);
    host_u.rd(i[7:0], rv);
    `CHK("reg", xr(i), rv)
  endtask : c

  // model follows the write before the host drives it
  task automatic w(input int i, input logic [15:0] d);
    logic lk;
    lk = |cfg[7:6];
    if (i == 1) begin
      if (!lk) {cfg[10:9], cfg[3], cfg[1:0]} = {d[10:9], d[3], d[1:0]};
      if (!d[8] || !lk) cfg[8] = d[8];
      if (!d[2] || !cfg[6]) cfg[2] = d[2];
      cfg[7:6] = cfg[7:6] | d[7:6];
    end else if (i == 4 ? !cfg[7] : (i == 2 || i == 3) && !cfg[6]) begin
      lim[i] = d & 16'h1FFC;
    end
    host_u.wr(i[7:0], d);
  endtask : w

  task automatic s(input logic [12:0] t);
    @(negedge clk);
    sv = 1'b1;
    st = t;
    @(negedge clk);
    sv = 1'b0;
    st = ~t;
    if (!cfg[8]) tmp = t;
  endtask : s

  task automatic ev(input int i, input logic [15:0] v, input logic x);
    if (i == 0) s(v[12:0]);
    else w(i, v);
    ea = x;
    repeat (3) @(negedge clk);
    `CHK("pin", (x & cfg[3]) ^ cfg[1], ev_oe)
    `CHK("od", 1'b0, ev_out)
    c(1);
  endtask : ev

  task automatic tdone(input string nm);
    $display("test %s done", nm);
  endtask : tdone

  task automatic finish_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("Error watchdog exp end got hang");
    finish_test();
  end

  initial begin
    nrst = 1'b0;
    sv = 1'b0;
    st = 13'h0000;
    seed = 32'h5904;
    n_fail = 0;
    checks = 0;
    rst_mdl();
    repeat (20) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    for (int i = 1; i <= 5; i++) c(i);
    `CHK("conv", 1'b1, conv)
    tdone("reset");
    for (int k = 0; k < 6; k++) begin
      for (int i = 2; i <= 4; i++) w(i, 16'($random(seed)));
      for (int i = 2; i <= 5; i++) c(i);
      s(13'($random(seed)));
      c(5);
    end
    for (int i = 2; i <= 4; i++) w(i, 16'h0190);
    for (int t = 16'h018F; t <= 16'h0191; t++) begin
      s(t[12:0]);
      c(5);
    end
    s(13'h1E70);
    c(5);
    w(5, 16'h1234);
    w(9, 16'h0FFC);
    for (int i = 2; i <= 5; i++) c(i);
    for (int h = 0; h < 4; h++) begin
      w(1, 16'hF820 | 16'(h << 9));
      c(1);
    end
    tdone("registers");
    w(1, 16'h0100);
    `CHK("conv", 1'b0, conv)
    s(13'h0555);
    c(5);
    c(5);
    w(1, 16'h0000);
    `CHK("conv", 1'b1, conv)
    tdone("power_down");
    w(2, 16'h0320);
    w(3, 16'h0000);
    w(4, 16'h07D0);
    s(13'h0190);
    ev(1, 16'h0008, 0);
    ev(2, 16'h0100, 1);
    ev(2, 16'h0320, 0);
    ev(0, 16'h0330, 1);
    ev(1, 16'h0028, 1);
    ev(1, 16'h000A, 1);
    ev(1, 16'h0002, 1);
    ev(0, 16'h0190, 0);
    ev(1, 16'h0000, 0);
    ev(1, 16'h0608, 0);
    ev(0, 16'h0330, 1);
    ev(0, 16'h0310, 1);
    ev(0, 16'h0290, 0);
    ev(0, 16'h1E70, 1);
    ev(0, 16'h0290, 0);
    tdone("comparator");
    w(1, 16'h0009);
    ev(1, 16'h0029, 0);
    ev(0, 16'h0330, 1);
    ev(1, 16'h0029, 0);
    ev(0, 16'h0190, 1);
    ev(1, 16'h0029, 0);
    ev(4, 16'h0500, 0);
    ev(2, 16'h07F0, 0);
    ev(0, 16'h0600, 1);
    ev(1, 16'h0029, 1);
    ev(0, 16'h0190, 0);
    tdone("interrupt");
    ev(2, 16'h0320, 0);
    ev(1, 16'h000C, 0);
    ev(0, 16'h0400, 0);
    ev(0, 16'h0600, 1);
    ev(1, 16'h002C, 1);
    ev(0, 16'h0190, 0);
    tdone("critical_only");
    w(1, 16'h0108);
    w(1, 16'h0148);
    c(1);
    w(1, 16'h0048);
    `CHK("conv", 1'b1, conv)
    w(1, 16'h0707);
    c(1);
    `CHK("conv", 1'b1, conv)
    w(2, 16'h0100);
    w(3, 16'h0100);
    w(4, 16'h0700);
    for (int i = 2; i <= 4; i++) c(i);
    w(1, 16'h0080);
    w(4, 16'h0200);
    w(1, 16'h0000);
    for (int i = 1; i <= 4; i++) c(i);
    tdone("locks");
    @(negedge clk);
    nrst = 1'b0;
    rst_mdl();
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    c(1);
    tdone("second_reset");
    finish_test();
  end
endmodule : tsc_sensor_regs_tb_top

bind tsc_sensor_regs tsc_sensor_regs_sva chk_u (
  .I_CLK(I_CLK), .I_NRST(I_NRST), .I_REG_INDEX(I_REG_INDEX), .I_REG_WR(I_REG_WR),
  .I_REG_WDATA(I_REG_WDATA), .O_REG_RDATA(O_REG_RDATA),
  .I_SAMPLE_VALID(I_SAMPLE_VALID), .I_SAMPLE_TEMP(I_SAMPLE_TEMP),
  .O_CONV_ENABLE(O_CONV_ENABLE), .O_EVENT_OUT(O_EVENT_OUT), .O_EVENT_OE(O_EVENT_OE));
`default_nettype wire
